// ===== rtl/scr_map.svh
// register offsets, field positions, reset values and timing figures of the config core
`ifndef SCR_MAP_SVH
`define SCR_MAP_SVH
`define SCR_AW 15
`define SCR_OFS_IFACE 15'h0000
`define SCR_OFS_PWR 15'h0002
`define SCR_OFS_MAKER_LO 15'h000C
`define SCR_OFS_MAKER_HI 15'h000D
`define SCR_OFS_USER 15'h0010
`define SCR_RST_IFACE 8'h30
`define SCR_RST_PWR 8'h00
`define SCR_RST_USER 8'h00
`define SCR_BIT_CHIP_RST 7
`define SCR_BIT_ASCEND 5
`define SCR_BIT_SO_FLAG 4
`define SCR_BIT_FREEZE 0
`define SCR_MODE_NORMAL 2'h0
`define SCR_MODE_PDN 2'h3
`define SCR_HDR_BITS 5'h10
`define SCR_BYTE_BITS 4'h8
`define SCR_RST_TIME_NS 750
`define SCR_CLK_MHZ 250
`endif

// ===== rtl/scr_pkg.sv
// types shared by the config core and its bench
package scr_pkg;
	// transfer phases of the serial slave
	typedef enum logic [1:0] {
		SCR_IDLE,
		SCR_HDR,
		SCR_DATA
	} scr_state_e;
	// configuration seen by the rest of the device
	typedef struct packed {
		logic chip_reset;
		logic power_down;
		logic [1:0] power_mode;
		logic ascend;
		logic addr_freeze;
	} scr_cfg_s;
endpackage : scr_pkg

// ===== rtl/scr_core.sv
// serial-port general configuration register core of the converter
//=====================================================================
`timescale 1ns/1ns
`include "scr_map.svh"
module scr_core #(
	parameter logic [15:0] MAKER_CODE = 16'h5A3C // arbitrary value, not any real maker
) (
	input wire logic clock,
	input wire logic arst_n,
	input wire logic spi_sclk,
	input wire logic spi_cs_n,
	input wire logic spi_sdi,
	output logic spi_sdo,
	output scr_pkg::scr_cfg_s cfg,
	output logic reset_busy
);
	// greatest-whole-cycle bound rounded down so the reset ends inside the limit
	localparam int RST_CYC_I = (`SCR_RST_TIME_NS * `SCR_CLK_MHZ) / 1000;
	localparam logic [7:0] RST_CYC = RST_CYC_I[7:0];
	generate
		if (RST_CYC_I < 1 || RST_CYC_I > 255)
		begin : g_bad_rst
			$error("reset interval does not fit the counter");
		end
	endgenerate

	//=====================================================================
	// reset release and pin synchronisers
	logic [1:0] rst_sync_reg;
	logic rst_n;
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
			rst_sync_reg <= 2'h0;
		else
			rst_sync_reg <= {rst_sync_reg[0], 1'b1};
	end
	assign rst_n = rst_sync_reg[1];

	// pins come from the host's clock, two flops before any use
	logic [2:0] meta_reg, sync_reg;
	logic sclk_d_reg;
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			meta_reg <= 3'h1;
			sync_reg <= 3'h1;
			sclk_d_reg <= 1'b0;
		end
		else
		begin
			meta_reg <= {spi_sclk, spi_sdi, spi_cs_n};
			sync_reg <= meta_reg;
			sclk_d_reg <= sync_reg[2];
		end
	end
	logic cs_n_s, sdi_s, sclk_rise, sclk_fall;
	assign cs_n_s = sync_reg[0];
	assign sdi_s = sync_reg[1];
	assign sclk_rise = sync_reg[2] && !sclk_d_reg;
	assign sclk_fall = !sync_reg[2] && sclk_d_reg;

	//=====================================================================
	// registers and helpers
	logic [7:0] iface_reg, pwr_reg, user_reg;
	logic [7:0] rst_cnt_reg;
	scr_pkg::scr_state_e state_reg;
	logic [4:0] bit_cnt_reg;
	logic [15:0] hdr_reg;
	logic [`SCR_AW-1:0] addr_reg;
	logic rd_reg;
	logic drop_reg;
	logic [7:0] rx_reg, tx_reg;

	// read view; reset request reads zero, serial-out flag reads one
	function automatic logic [7:0] rd_byte(input logic [`SCR_AW-1:0] a);
		logic [7:0] v;
		v = 8'h00;
		if (a == `SCR_OFS_IFACE)
		begin
			v = iface_reg;
			v[`SCR_BIT_CHIP_RST] = 1'b0;
			v[`SCR_BIT_SO_FLAG] = 1'b1;
		end
		else if (a == `SCR_OFS_PWR)
			v = pwr_reg;
		else if (a == `SCR_OFS_MAKER_LO)
			v = MAKER_CODE[7:0];
		else if (a == `SCR_OFS_MAKER_HI)
			v = MAKER_CODE[15:8];
		else if (a == `SCR_OFS_USER)
			v = user_reg;
		return v;
	endfunction : rd_byte

	// next streaming address: hold, up or down by exactly one
	function automatic logic [`SCR_AW-1:0] step(input logic [`SCR_AW-1:0] a);
		logic [`SCR_AW-1:0] n;
		n = a;
		if (user_reg[`SCR_BIT_FREEZE])
			n = a;
		else if (iface_reg[`SCR_BIT_ASCEND])
			n = a + `SCR_AW'(1);
		else
			n = a - `SCR_AW'(1);
		return n;
	endfunction : step

	logic hdr_done, byte_done, wr_strobe, rst_req;
	logic [7:0] wr_byte;
	assign hdr_done = (state_reg == scr_pkg::SCR_HDR) && sclk_rise
		&& (bit_cnt_reg == `SCR_HDR_BITS - 5'h1);
	assign byte_done = (state_reg == scr_pkg::SCR_DATA) && sclk_rise
		&& (bit_cnt_reg == 5'(`SCR_BYTE_BITS) - 5'h1);
	assign wr_byte = {rx_reg[6:0], sdi_s};
	assign wr_strobe = byte_done && !rd_reg;
	assign rst_req = wr_strobe && (addr_reg == `SCR_OFS_IFACE)
		&& wr_byte[`SCR_BIT_CHIP_RST];

	//=====================================================================
	// chip reset interval counter
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			rst_cnt_reg <= 8'h00;
		else if (rst_req)
			rst_cnt_reg <= RST_CYC;
		else if (rst_cnt_reg != 8'h00)
			rst_cnt_reg <= rst_cnt_reg - 8'h01;
	end
	assign reset_busy = (rst_cnt_reg != 8'h00);

	//=====================================================================
	// configuration registers; held at reset values throughout the interval
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			iface_reg <= `SCR_RST_IFACE;
			pwr_reg <= `SCR_RST_PWR;
			user_reg <= `SCR_RST_USER;
		end
		else if (rst_req || reset_busy)
		begin
			iface_reg <= `SCR_RST_IFACE;
			pwr_reg <= `SCR_RST_PWR;
			user_reg <= `SCR_RST_USER;
		end
		else if (wr_strobe)
		begin
			// maker code and serial-out flag have no storage to write
			if (addr_reg == `SCR_OFS_IFACE)
			begin
				iface_reg <= wr_byte;
				iface_reg[`SCR_BIT_SO_FLAG] <= 1'b1;
			end
			else if (addr_reg == `SCR_OFS_PWR)
				pwr_reg <= wr_byte;
			else if (addr_reg == `SCR_OFS_USER)
				user_reg <= wr_byte;
		end
	end

	//=====================================================================
	// serial transfer sequencing: 16-bit header, then streamed bytes
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_reg <= scr_pkg::SCR_IDLE;
			bit_cnt_reg <= 5'h00;
			hdr_reg <= 16'h0000;
			addr_reg <= '0;
			rd_reg <= 1'b0;
			rx_reg <= 8'h00;
			drop_reg <= 1'b0;
		end
		else if (cs_n_s || reset_busy)
		begin
			// a frame begun inside the reset interval is dropped whole:
			// stay idle until select lifts, so its tail is never decoded
			state_reg <= scr_pkg::SCR_IDLE;
			bit_cnt_reg <= 5'h00;
			drop_reg <= reset_busy && !cs_n_s;
		end
		else
		begin
			case (state_reg)
				scr_pkg::SCR_IDLE:
				begin
					if (!drop_reg)
						state_reg <= scr_pkg::SCR_HDR;
					bit_cnt_reg <= 5'h00;
				end
				scr_pkg::SCR_HDR:
				begin
					if (sclk_rise)
					begin
						hdr_reg <= {hdr_reg[14:0], sdi_s};
						bit_cnt_reg <= bit_cnt_reg + 5'h01;
						if (hdr_done)
						begin
							rd_reg <= hdr_reg[14];
							addr_reg <= {hdr_reg[13:0], sdi_s};
							bit_cnt_reg <= 5'h00;
							state_reg <= scr_pkg::SCR_DATA;
						end
					end
				end
				scr_pkg::SCR_DATA:
				begin
					if (sclk_rise)
					begin
						rx_reg <= wr_byte;
						bit_cnt_reg <= bit_cnt_reg + 5'h01;
						if (byte_done)
						begin
							bit_cnt_reg <= 5'h00;
							addr_reg <= step(addr_reg);
						end
					end
				end
				default:
					state_reg <= scr_pkg::SCR_IDLE;
			endcase
		end
	end

	//=====================================================================
	// read data out on SDO, changed on falling clock edges
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			tx_reg <= 8'h00;
			spi_sdo <= 1'b0;
		end
		else if (hdr_done)
			tx_reg <= rd_byte({hdr_reg[13:0], sdi_s});
		else if (byte_done)
			tx_reg <= rd_byte(step(addr_reg));
		else if (sclk_fall && state_reg == scr_pkg::SCR_DATA && rd_reg && !cs_n_s)
		begin
			spi_sdo <= tx_reg[7];
			tx_reg <= {tx_reg[6:0], 1'b0};
		end
	end

	//=====================================================================
	// registered configuration outputs
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			cfg <= '0;
		else
		begin
			cfg.chip_reset <= rst_req || reset_busy;
			cfg.power_mode <= pwr_reg[1:0];
			cfg.power_down <= (pwr_reg[1:0] == `SCR_MODE_PDN);
			cfg.ascend <= iface_reg[`SCR_BIT_ASCEND];
			cfg.addr_freeze <= user_reg[`SCR_BIT_FREEZE];
		end
	end
endmodule : scr_core

// ===== tb/scr_core_monitor.sv
// port-level checker for the config core
`timescale 1ns/1ns
module scr_core_monitor (
	input logic clock,
	input logic arst_n,
	input logic spi_sclk,
	input logic spi_cs_n,
	input logic spi_sdi,
	input logic spi_sdo,
	input scr_pkg::scr_cfg_s cfg,
	input logic reset_busy
);
	//==========
	// port relations, all gated by reset
	default clocking @(posedge clock);
	endclocking
	default disable iff (!arst_n);
	property p_pdn; cfg.power_down == &cfg.power_mode; endproperty
	a_pdn: assert property (p_pdn) else $error("power down flag wrong");
	property p_busy_len; $rose(reset_busy) |-> ##[1:187] !reset_busy; endproperty
	a_busy_len: assert property (p_busy_len) else $error("reset too long");
	property p_chip; $rose(reset_busy) |-> ##[0:1] cfg.chip_reset; endproperty
	a_chip: assert property (p_chip) else $error("chip reset not shown");
	property p_after; $fell(reset_busy) |-> ##[0:2] cfg[3:0] == 4'h2; endproperty
	a_after: assert property (p_after) else $error("cfg not at reset value");
	property p_frozen; reset_busy [*2] |=> $stable(cfg[4:0]); endproperty
	a_frozen: assert property (p_frozen) else $error("cfg moved in reset");
	// only a frame may change cfg; chip_reset left out as it drops after the reset interval, ascend as it settles after reset
	property p_idle_cfg; spi_cs_n [*8] |-> $stable({cfg[4:2], cfg[0]}); endproperty
	a_idle_cfg: assert property (p_idle_cfg) else $error("cfg moved idle");
	property p_idle_sdo; spi_cs_n [*6] |-> $stable(spi_sdo); endproperty
	a_idle_sdo: assert property (p_idle_sdo) else $error("sdo moved idle");
	property p_sdo_fall; $changed(spi_sdo) |-> !$past(spi_sclk) && !$past(spi_sclk, 2);
	endproperty
	a_sdo_fall: assert property (p_sdo_fall) else $error("sdo not after fall");
endmodule : scr_core_monitor
bind scr_core scr_core_monitor u_mon (.clock(clock), .arst_n(arst_n), .spi_sclk(spi_sclk),
	.spi_cs_n(spi_cs_n), .spi_sdi(spi_sdi), .spi_sdo(spi_sdo), .cfg(cfg),
	.reset_busy(reset_busy));

// ===== tb/scr_host.sv
// serial host model that frames register transfers
`timescale 1ns/1ns
module scr_host (
	input logic clock,
	input logic spi_sdo,
	output logic spi_sclk,
	output logic spi_cs_n,
	output logic spi_sdi
);
	//==========
	// idle: clock parked low, select high
	initial
	begin
		spi_sclk = 1'b0;
		spi_cs_n = 1'b1;
		spi_sdi = 1'b0;
	end
	// mode 0, four clocks a phase; n bytes right-aligned in wd and rd
	task automatic frame(input logic [15:0] hdr, input int n, input logic [31:0] wd,
		output logic [31:0] rd);
		logic [47:0] sh;
		sh = {hdr, wd << (32 - 8 * n)};
		rd = 32'h0;
		spi_cs_n = 1'b0;
		repeat (4) @(negedge clock);
		for (int i = 0; i < 16 + 8 * n; i++)
		begin
			spi_sdi = sh[47 - i];
			repeat (4) @(negedge clock);
			rd = {rd[30:0], spi_sdo};
			spi_sclk = 1'b1;
			repeat (4) @(negedge clock);
			spi_sclk = 1'b0;
		end
		repeat (4) @(negedge clock);
		spi_cs_n = 1'b1;
		spi_sdi = ~spi_sdi; // released line must not look like held data
		repeat (4) @(negedge clock);
	endtask : frame
endmodule : scr_host

// ===== tb/spi_config_register_core_tb.sv
// self-checking bench for the config core
`timescale 1ns/1ns
module spi_config_register_core_tb;
	typedef struct packed {
		logic [15:0] h;
		logic [2:0] n;
		logic [31:0] w;
		logic [31:0] e;
		logic [5:0] c;
	} scr_row_s;
	localparam logic [15:0] MC = 16'hC35A; // arbitrary value
	logic clock = 1'b0;
	logic arst_n = 1'b0;
	logic spi_sclk, spi_cs_n, spi_sdi, spi_sdo, reset_busy;
	scr_pkg::scr_cfg_s cfg;
	logic [31:0] rd;
	int fail_count = 0;
	int samples_checked = 0;
	int busy_cnt = 0;
	// frame, expected read bytes, expected cfg afterwards
	scr_row_s rows [13] = '{
		'{16'h8000, 3'd1, 32'h0, 32'h30, 6'h02},
		'{16'h800C, 3'd2, 32'h0, {MC[7:0], MC[15:8]}, 6'h02},
		'{16'h0002, 3'd1, 32'h1, 32'h0, 6'h06},
		'{16'h0002, 3'd1, 32'h2, 32'h0, 6'h0A},
		'{16'h0002, 3'd1, 32'h3, 32'h0, 6'h1E},
		'{16'h8002, 3'd1, 32'h0, 32'h3, 6'h1E},
		'{16'h000C, 3'd2, 32'hFFFF, 32'h0, 6'h1E},
		'{16'h0000, 3'd1, 32'h0, 32'h0, 6'h1C},
		'{16'h8000, 3'd1, 32'h0, 32'h10, 6'h1C},
		'{16'h800D, 3'd2, 32'h0, {MC[15:8], MC[7:0]}, 6'h1C},
		'{16'h0010, 3'd1, 32'h1, 32'h0, 6'h1D},
		'{16'h800C, 3'd2, 32'h0, {MC[7:0], MC[7:0]}, 6'h1D},
		'{16'h8011, 3'd1, 32'h0, 32'h0, 6'h1D}};
	//==========
	// clock, parts and helpers
	always #2 clock = ~clock;
	// counted on the falling edge, where the busy level has settled
	always @(negedge clock) if (reset_busy === 1'b1) busy_cnt <= busy_cnt + 1;
	scr_core #(.MAKER_CODE(MC)) dut (.clock(clock), .arst_n(arst_n), .spi_sclk(spi_sclk),
		.spi_cs_n(spi_cs_n), .spi_sdi(spi_sdi), .spi_sdo(spi_sdo), .cfg(cfg),
		.reset_busy(reset_busy));
	scr_host host (.clock(clock), .spi_sdo(spi_sdo), .spi_sclk(spi_sclk),
		.spi_cs_n(spi_cs_n), .spi_sdi(spi_sdi));
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		samples_checked++;
		if (s !== e)
		begin
			fail_count++;
			$display("FAIL %s expected %h seen %h", nm, e, s);
		end
	endtask : chk
	task automatic wrap_up;
		if (fail_count == 0 && samples_checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : wrap_up
	//==========
	// table pass, then resets
	initial
	begin
		repeat (16) @(negedge clock);
		arst_n = 1'b1;
		repeat (8) @(negedge clock);
		for (int i = 0; i < 13; i++)
		begin
			host.frame(rows[i].h, rows[i].n, rows[i].w, rd);
			if (rows[i].h[15])
				chk("read", rows[i].e, rd & ((32'h1 << (8 * rows[i].n)) - 1));
			chk("cfg", rows[i].c, {26'h0, cfg});
		end
		arst_n = 1'b0;
		@(negedge clock);
		chk("cfg in reset", 32'h0, {26'h0, cfg});
		arst_n = 1'b1;
		repeat (8) @(negedge clock);
		chk("cfg after reset", 32'h2, {26'h0, cfg});
		host.frame(16'h0002, 1, 32'h3, rd);
		chk("cfg before chip reset", 32'h1E, {26'h0, cfg});
		host.frame(16'h0000, 1, 32'hB0, rd);
		// bounded wait; no frame until the reset interval ends
		for (int k = 0; k < 300 && reset_busy !== 1'b0; k++) @(negedge clock);
		chk("busy", 32'h0, {31'h0, reset_busy});
		chk("busy cycles", 32'd187, busy_cnt);
		// cfg is registered, so chip_reset drops one cycle after busy
		@(negedge clock);
		chk("cfg chip reset", 32'h2, {26'h0, cfg});
		// a hung reset interval skips the last frame and goes to the report
		if (reset_busy === 1'b0)
		begin
			host.frame(16'h8000, 1, 32'h0, rd);
			chk("self clear", 32'h30, rd & 32'hFF);
		end
		wrap_up();
	end
endmodule : spi_config_register_core_tb
